// ==== hw/dram_slice_pkg.sv ====
package dram_slice_pkg;
   localparam int guard_width = 4;
   localparam logic [3:0] guard_default = 4'h0;
   localparam int age_width = 4;
   localparam logic [3:0] age_top = 4'hf;
   localparam logic [3:0] score_top = 4'hf;
   localparam int lane_count = 8;
   localparam int lane_result_width = 8;
   localparam int clk_period_ns = 8;
   localparam int zqcl_time_ns = 360;
   localparam int zqcs_time_ns = 90;
   localparam int zqcl_cycles = (zqcl_time_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int zqcs_cycles = (zqcs_time_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int zq_count_width = 10;
   localparam logic [9:0] zq_count_one = 10'h001;
   typedef enum logic [1:0] {zq_short_type, zq_long_type, zq_none_type} zq_kind_type;
endpackage

// ==== hw/zq_ctrl_if.sv ====
`timescale 1ns/1ns
interface zq_ctrl_if;
   logic start;
   logic long_cal;
   logic cs_sel;
   logic busy;
   logic hold_traffic;
   logic done;
   logic cmd_valid;
   logic cmd_long;
   logic [1:0] cmd_cs;
   modport master(output start, output long_cal, output cs_sel,
                  input busy, input hold_traffic, input done,
                  input cmd_valid, input cmd_long, input cmd_cs);
   modport engine(input start, input long_cal, input cs_sel,
                  output busy, output hold_traffic, output done,
                  output cmd_valid, output cmd_long, output cmd_cs);
endinterface

// ==== hw/zq_engine.sv ====
`timescale 1ns/1ns
module zq_engine (
   input wire logic core_clk, // controller clock
   input wire logic rstn,     // async reset, active low
   zq_ctrl_if.engine zq       // calibration request and status
);
   import dram_slice_pkg::*;

   logic [zq_count_width-1:0] wait_count;
   logic running;

   // only one command can be in flight, so the ranks never calibrate together
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         running <= 1'b0;
         wait_count <= '0;
         zq.cmd_valid <= 1'b0;
         zq.cmd_long <= 1'b0;
         zq.cmd_cs <= 2'h0;
         zq.done <= 1'b0;
      end else begin
         zq.cmd_valid <= 1'b0;
         zq.done <= 1'b0;
         if (!running && zq.start) begin // R4 R11
            running <= 1'b1;
            zq.cmd_valid <= 1'b1;
            zq.cmd_long <= zq.long_cal;
            zq.cmd_cs <= zq.cs_sel ? 2'h2 : 2'h1;
            wait_count <= zq.long_cal ? zq_count_width'(zqcl_cycles)
                                      : zq_count_width'(zqcs_cycles);
         end else if (running) begin
            if (wait_count == zq_count_one) begin // R6
               running <= 1'b0;
               zq.done <= 1'b1; // R11
            end
            wait_count <= wait_count - zq_count_one;
         end
      end
   end

   assign zq.busy = running;
   assign zq.hold_traffic = running; // R6

   no_overlap_a: assert property (@(posedge core_clk) disable iff (!rstn) // R4
      zq.cmd_valid |=> !zq.cmd_valid [*8])
      else $error("second zq command during calibration");
   hold_span_a: assert property (@(posedge core_clk) disable iff (!rstn) // R6
      (zq.cmd_valid && !zq.cmd_long) |-> zq.hold_traffic [*8])
      else $error("traffic released early");
   done_after_a: assert property (@(posedge core_clk) disable iff (!rstn) // R11
      (zq.cmd_valid && !zq.cmd_long) |-> ##12 zq.done)
      else $error("short calibration done not on time");
   one_cs_a: assert property (@(posedge core_clk) disable iff (!rstn) // R4
      zq.cmd_valid |-> $onehot(zq.cmd_cs))
      else $error("zq command to both ranks");
   short_cal_c: cover property (@(posedge core_clk) disable iff (!rstn)
      zq.cmd_valid && !zq.cmd_long);
   long_cal_c: cover property (@(posedge core_clk) disable iff (!rstn)
      zq.cmd_valid && zq.cmd_long);
endmodule

// ==== hw/dram_reorder_and_calibration.sv ====
`timescale 1ns/1ns
// Contract
// R1: pending access reaching top score waits guard count more cycles, then gets top priority.
// R2: access whose age reaches 15 is tagged highest priority.
// R3: software should program guard count to zero.
// R4: never calibrate both chip selects at once; serialize calibrations.
// R5: with auto calibration off, software blocks traffic and staggers calibration commands.
// R6: after a calibration command, hold all data transfers until its interval passes.
// R7: memory clock enable stays low and glitch free through power-up.
// R8: init issues precharge-all to every chip select before any mode register write.
// R9: write leveling failure sets per-lane error flag that stays until read.
// R10: lane result stays non-zero on success; zero on an active lane means failure.
// R11: software command path issues one calibration to one rank, reports completion.
module dram_reorder_and_calibration (
   input wire logic core_clk, // controller clock
   input wire logic rstn, // async reset, active low
   input wire logic [dram_slice_pkg::guard_width-1:0] reorder_guard_count, // guard cycles
   input wire logic req_pending, // an access waits in the reorder queue
   input wire logic req_grant, // the queued access was served
   input wire logic [3:0] req_score, // dynamic score of the waiting access
   input wire logic cke_enable, // init sequencer asks for clock enable high
   input wire logic sw_zq_start, // software calibration request
   input wire logic sw_zq_long, // 1 long, 0 short
   input wire logic sw_zq_cs, // target chip select
   input wire logic auto_zq_tick, // periodic automatic short calibration
   input wire logic auto_zq_en, // automatic calibration on
   input wire logic wl_active, // hardware write leveling running
   input wire logic [dram_slice_pkg::lane_count-1:0] wl_lane_used, // lanes in use
   input wire logic [dram_slice_pkg::lane_count-1:0] wl_lane_fail, // per-lane failure
   input wire logic wl_lane_load, // leveling results valid this cycle
   input wire logic [dram_slice_pkg::lane_count*dram_slice_pkg::lane_result_width-1:0]
      wl_lane_value, // per-lane leveling delay results
   input wire logic wl_flags_clear, // software has read the flags
   output logic req_top_priority, // access tagged highest priority
   output logic dram_clock_enable_out, // memory clock enable pin
   output logic zq_cmd_valid, // calibration command pulse
   output logic zq_cmd_long, // long calibration
   output logic [1:0] zq_cmd_cs, // one-hot chip select
   output logic zq_hold_traffic, // block data transfers
   output logic zq_busy, // calibration running
   output logic zq_done, // calibration completed pulse, for software and automatic calibrations
   output logic [dram_slice_pkg::lane_count-1:0] wl_lane_error_flags, // sticky lane errors
   output logic [dram_slice_pkg::lane_count*dram_slice_pkg::lane_result_width-1:0]
      wl_lane_result_reg // held lane results
);
   import dram_slice_pkg::*;

   // an access leaves the queue when it is served or withdrawn
   function automatic logic queue_clear(input logic pending, input logic served);
      return !pending || served;
   endfunction

   // only lanes in use can report a leveling failure
   function automatic logic [lane_count-1:0] lane_faults(input logic [lane_count-1:0] fail,
                                                        input logic [lane_count-1:0] used);
      return fail & used;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic [age_width-1:0] age;
   logic [guard_width-1:0] guard_left;
   logic top_reached;

   // age saturates at top so the tag never falls off while the access waits
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         age <= '0;
      end else if (queue_clear(req_pending, req_grant)) begin
         age <= '0;
      end else if (age != age_top) begin
         age <= age + 4'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         top_reached <= 1'b0;
         guard_left <= guard_default;
      end else if (queue_clear(req_pending, req_grant)) begin
         top_reached <= 1'b0;
         guard_left <= guard_default;
      end else if (!top_reached && req_score == score_top) begin
         top_reached <= 1'b1; // R1
         guard_left <= reorder_guard_count;
      end else if (top_reached && guard_left != '0) begin
         guard_left <= guard_left - 4'h1; // R1
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         req_top_priority <= 1'b0;
      end else begin
         req_top_priority <= !queue_clear(req_pending, req_grant) &&
            ((top_reached && guard_left == '0) || age == age_top); // R1 R2
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   zq_ctrl_if zq ();
   logic auto_cs;

   // software command wins; automatic ticks alternate ranks so they never coincide
   assign zq.start = sw_zq_start || (auto_zq_en && auto_zq_tick); // R4 R11
   assign zq.long_cal = sw_zq_start ? sw_zq_long : 1'b0;
   assign zq.cs_sel = sw_zq_start ? sw_zq_cs : auto_cs;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         auto_cs <= 1'b0;
      end else if (!sw_zq_start && auto_zq_en && auto_zq_tick && !zq.busy) begin
         auto_cs <= !auto_cs; // R4
      end
   end

   zq_engine engine (
      .core_clk(core_clk),
      .rstn(rstn),
      .zq(zq.engine)
   );

   assign zq_cmd_valid = zq.cmd_valid;
   assign zq_cmd_long = zq.cmd_long;
   assign zq_cmd_cs = zq.cmd_cs;
   assign zq_done = zq.done;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         zq_hold_traffic <= 1'b0;
         zq_busy <= 1'b0;
      end else begin
         zq_hold_traffic <= zq.hold_traffic || zq.start; // R6
         zq_busy <= zq.busy;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // enable is synchronised so a pin glitch cannot pass; reset forces it low
   logic cke_meta;
   logic cke_sync;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cke_meta <= 1'b0;
         cke_sync <= 1'b0;
      end else begin
         cke_meta <= cke_enable;
         cke_sync <= cke_meta;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dram_clock_enable_out <= 1'b0; // R7
      end else begin
         dram_clock_enable_out <= cke_sync; // R7
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // set wins over clear, so a failure in the clearing cycle survives
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wl_lane_error_flags <= '0;
      end else begin
         wl_lane_error_flags <= (wl_flags_clear ? '0 : wl_lane_error_flags) |
            (wl_active ? lane_faults(wl_lane_fail, wl_lane_used) : '0); // R9
      end
   end

   // failed or unused lanes store zero so a zero result marks failure
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wl_lane_result_reg <= '0;
      end else if (wl_lane_load) begin
         for (int i = 0; i < lane_count; i++) begin
            wl_lane_result_reg[i*lane_result_width +: lane_result_width] <=
               (wl_lane_used[i] && !wl_lane_fail[i])
                  ? wl_lane_value[i*lane_result_width +: lane_result_width]
                  : '0; // R10
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   age_tag_a: assert property (@(posedge core_clk) disable iff (!rstn) // R2
      (req_pending && !req_grant && age == age_top) |=> req_top_priority)
      else $error("aged access not tagged");
   grant_clear_a: assert property (@(posedge core_clk) disable iff (!rstn) // R2
      queue_clear(req_pending, req_grant) |=> !req_top_priority)
      else $error("priority kept after grant");
   guard_wait_a: assert property (@(posedge core_clk) disable iff (!rstn) // R1
      (req_top_priority && age != age_top) |-> top_reached)
      else $error("priority before top score");
   cke_reset_a: assert property (@(posedge core_clk) disable iff (!rstn) // R7
      $rose(dram_clock_enable_out) |-> $past(cke_enable, 3))
      else $error("clock enable rose without request");
   cke_drop_a: assert property (@(posedge core_clk) disable iff (!rstn) // R7
      $fell(dram_clock_enable_out) |-> !$past(cke_enable, 3))
      else $error("clock enable fell without request");
   flag_sticky_a: assert property (@(posedge core_clk) disable iff (!rstn) // R9
      (wl_lane_error_flags != '0 && !wl_flags_clear) |=>
         ((wl_lane_error_flags & $past(wl_lane_error_flags)) ==
          $past(wl_lane_error_flags)))
      else $error("error flag lost before read");
   set_wins_a: assert property (@(posedge core_clk) disable iff (!rstn) // R9
      (wl_active && wl_flags_clear && lane_faults(wl_lane_fail, wl_lane_used) != '0) |=>
         ((wl_lane_error_flags & $past(wl_lane_fail & wl_lane_used)) ==
          $past(wl_lane_fail & wl_lane_used)))
      else $error("failure lost to a clear");
   hold_follow_a: assert property (@(posedge core_clk) disable iff (!rstn) // R6
      zq_cmd_valid |=> zq_hold_traffic [*4])
      else $error("traffic not held");
   hold_release_a: assert property (@(posedge core_clk) disable iff (!rstn) // R6
      $fell(zq_hold_traffic) |-> $past(zq_done))
      else $error("traffic released before calibration end");
   result_zero_a: assert property (@(posedge core_clk) disable iff (!rstn) // R10
      (wl_lane_load && wl_lane_fail[0]) |=>
         wl_lane_result_reg[lane_result_width-1:0] == '0)
      else $error("failed lane result not zero");
   aged_c: cover property (@(posedge core_clk) disable iff (!rstn) $rose(req_top_priority));
   wl_err_c: cover property (@(posedge core_clk) disable iff (!rstn) wl_lane_error_flags != '0);
   sw_done_c: cover property (@(posedge core_clk) disable iff (!rstn) zq_done);
endmodule

// ==== bench/dram_device_model.sv ====
`timescale 1ns/1ns
module dram_device_model (
   input wire logic core_clk, // controller clock
   input wire logic rstn, // async reset, active low
   input wire logic cmd_valid, // calibration command
   input wire logic cmd_long, // long calibration
   input wire logic [1:0] cmd_cs, // one-hot rank
   output logic [7:0] fault_cnt // misuse seen by the dies
);
   import dram_slice_pkg::*;
   int busy_left;
   // shared resistor: a command inside a running window spoils both ranks
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         busy_left <= 0;
         fault_cnt <= 8'h00;
      end else if (cmd_valid) begin
         if (busy_left > 0 || !$onehot(cmd_cs)) fault_cnt <= fault_cnt + 8'h01;
         busy_left <= cmd_long ? zqcl_cycles : zqcs_cycles;
      end else if (busy_left > 0) begin
         busy_left <= busy_left - 1;
      end
   end
endmodule

// ==== bench/dram_reorder_and_calibration_tb.sv ====
`timescale 1ns/1ns
module dram_reorder_and_calibration_tb;
   import dram_slice_pkg::*;
   logic core_clk, rstn, req_pending, req_grant, cke_enable, sw_zq_start, sw_zq_long, sw_zq_cs;
   logic auto_zq_tick, auto_zq_en, wl_active, wl_lane_load, wl_flags_clear;
   logic [3:0] reorder_guard_count, req_score;
   logic [7:0] wl_lane_used, wl_lane_fail, wl_lane_error_flags, fault_cnt;
   logic [63:0] wl_lane_value, wl_lane_result_reg;
   logic req_top_priority, dram_clock_enable_out, zq_cmd_valid, zq_cmd_long;
   logic zq_hold_traffic, zq_busy, zq_done;
   logic [1:0] zq_cmd_cs;
   int error_cnt = 0;
   int comparisons = 0;
   dram_reorder_and_calibration uut (
      .core_clk(core_clk), .rstn(rstn), .reorder_guard_count(reorder_guard_count),
      .req_pending(req_pending), .req_grant(req_grant), .req_score(req_score),
      .cke_enable(cke_enable), .sw_zq_start(sw_zq_start), .sw_zq_long(sw_zq_long),
      .sw_zq_cs(sw_zq_cs), .auto_zq_tick(auto_zq_tick), .auto_zq_en(auto_zq_en),
      .wl_active(wl_active), .wl_lane_used(wl_lane_used), .wl_lane_fail(wl_lane_fail),
      .wl_lane_load(wl_lane_load), .wl_lane_value(wl_lane_value),
      .wl_flags_clear(wl_flags_clear), .req_top_priority(req_top_priority),
      .dram_clock_enable_out(dram_clock_enable_out), .zq_cmd_valid(zq_cmd_valid),
      .zq_cmd_long(zq_cmd_long), .zq_cmd_cs(zq_cmd_cs), .zq_hold_traffic(zq_hold_traffic),
      .zq_busy(zq_busy), .zq_done(zq_done), .wl_lane_error_flags(wl_lane_error_flags),
      .wl_lane_result_reg(wl_lane_result_reg)
   );
   dram_device_model mem (.core_clk(core_clk), .rstn(rstn), .cmd_valid(zq_cmd_valid),
      .cmd_long(zq_cmd_long), .cmd_cs(zq_cmd_cs), .fault_cnt(fault_cnt));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic t_cke();
      cke_enable = 1'b1;
      // two flops of synchroniser plus the output flop: high after the third edge
      repeat (2) @(negedge core_clk);
      chk("cke early", 64'h0, dram_clock_enable_out);
      @(negedge core_clk);
      chk("cke on", 64'h1, dram_clock_enable_out);
   endtask
   task automatic t_age(logic [3:0] guard, logic [3:0] score, int lo, int hi);
      int n;
      reorder_guard_count = guard;
      req_score = score;
      req_pending = 1'b1;
      for (n = 1; n < hi && req_top_priority !== 1'b1; n++) @(negedge core_clk);
      chk("aging start", 64'h1, n > lo && n < hi);
      req_grant = 1'b1;
      req_pending = 1'b0;
      @(negedge core_clk);
      req_grant = 1'b0;
      @(negedge core_clk);
      chk("aging cleared", 64'h0, req_top_priority);
   endtask
   // one calibration; a second start inside the window must be ignored
   task automatic t_zq(logic lng, logic cs, logic use_auto);
      int n, extra;
      extra = 0;
      sw_zq_long = lng;
      sw_zq_cs = cs;
      if (use_auto) auto_zq_tick = 1'b1;
      else sw_zq_start = 1'b1;
      @(negedge core_clk);
      {sw_zq_start, auto_zq_tick} = 2'b00;
      for (n = 0; n < 4 && zq_cmd_valid !== 1'b1; n++) @(negedge core_clk);
      chk("zq long", lng, zq_cmd_long);
      if (!use_auto) chk("zq cs", cs ? 2'b10 : 2'b01, zq_cmd_cs);
      chk("zq hold", 64'h1, zq_hold_traffic);
      for (n = 0; n < 60 && zq_done !== 1'b1; n++) begin
         @(negedge core_clk);
         sw_zq_start = (n == 3);
         if (zq_cmd_valid === 1'b1) extra++;
         if (zq_done !== 1'b1 && zq_hold_traffic !== 1'b1) extra++;
      end
      chk("zq length", lng ? zqcl_cycles : zqcs_cycles, n);
      chk("zq overlap", 64'h0, extra);
      @(negedge core_clk);
      chk("zq idle", 64'h0, {zq_busy, zq_hold_traffic});
   endtask
   task automatic t_auto();
      logic [1:0] first;
      auto_zq_en = 1'b1;
      t_zq(1'b0, 1'b0, 1'b1);
      first = zq_cmd_cs;
      t_zq(1'b0, 1'b0, 1'b1);
      chk("auto ranks differ", 64'h1, first != zq_cmd_cs);
      auto_zq_en = 1'b0;
   endtask
   task automatic t_wl();
      logic [63:0] exp;
      wl_lane_used = 8'h0f;
      wl_active = 1'b1;
      wl_lane_fail = 8'h05;
      @(negedge core_clk);
      // failing lanes still flagged when results load, so they must store zero
      wl_lane_load = 1'b1;
      for (int i = 0; i < 8; i++) wl_lane_value[i*8 +: 8] = 8'(8'h11 * (i + 1));
      for (int i = 0; i < 8; i++)
         exp[i*8 +: 8] = (i == 1 || i == 3) ? 8'(8'h11 * (i + 1)) : 8'h00;
      @(negedge core_clk);
      {wl_lane_load, wl_active, wl_lane_fail} = 10'h000;
      repeat (5) @(negedge core_clk);
      chk("wl flags", 64'h05, wl_lane_error_flags);
      chk("wl results", exp, wl_lane_result_reg);
      wl_flags_clear = 1'b1;
      @(negedge core_clk);
      wl_flags_clear = 1'b0;
      @(negedge core_clk);
      chk("wl cleared", 64'h0, wl_lane_error_flags);
      // a failure in the clearing cycle must survive
      {wl_active, wl_lane_fail, wl_flags_clear} = {1'b1, 8'h02, 1'b1};
      @(negedge core_clk);
      {wl_active, wl_lane_fail, wl_flags_clear} = {1'b0, 8'h00, 1'b0};
      chk("wl set wins", 64'h02, wl_lane_error_flags);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rstn, req_pending, req_grant, cke_enable, sw_zq_start, sw_zq_long, sw_zq_cs} = 7'h0;
      {auto_zq_tick, auto_zq_en, wl_active, wl_lane_load, wl_flags_clear} = 5'h0;
      {reorder_guard_count, req_score, wl_lane_used, wl_lane_fail, wl_lane_value} = 'h0;
      repeat (16) @(negedge core_clk);
      chk("cke in reset", 64'h0, dram_clock_enable_out);
      rstn = 1'b1;
      @(negedge core_clk);
      // bench acts as init sequencer: clock enable comes up before any mode write
      t_cke();
      t_age(guard_default, 4'h3, 16, 18);
      t_age(4'h4, score_top, 6, 8);
      // software path with auto calibration off, one rank after the other
      t_zq(1'b0, 1'b0, 1'b0);
      t_zq(1'b1, 1'b1, 1'b0);
      t_auto();
      t_wl();
      chk("device faults", 64'h0, fault_cnt);
      stop_test();
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      error_cnt++;
      $display("[FAIL] watchdog expected finish seen timeout");
      stop_test();
   end
endmodule
